/* src/irrc_decoder.sv */
// Remote-control frame receiver with edge capture and Wishbone registers
// Behaviour
// - Capture base timer on both waveform edges
// - Base timer counts peripheral clock divided by 50
// - Tick timer reloads 25000-1, one ms period
// - Frame timer counts 140 ticks per window
// - First frame: leader, four bytes, stop, space
// - Repeat frame: leader and stop bit only
// - Windows and frame limit carry 30 percent margin
// - After leader: custom, data, stop, space
// - Bad interval abandons frame; next edge leads
// - Complete when frame time elapses during space
// - Leader within frame after space means repeat
// - Leader high, leader low, space windows
// - Code high, zero low, stop bit window
// - Long low interval decodes as one bit
// - Repeat leader low and repeat space windows
//
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module irrc_decoder #(
	parameter int unsigned TICK_RELOAD = irrc_pkg::TICK_RELOAD,
	parameter int unsigned FRAME_RELOAD = irrc_pkg::FRAME_RELOAD,
	parameter int unsigned PCLK_DIV = irrc_pkg::PCLK_DIV,
	parameter int unsigned BT_DIV = irrc_pkg::BT_DIV
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic remote_waveform_i,
	output logic irq_o
);
	irrc_tmr_if tif(); // Divider and frame timer link

	irrc_timers #(
		.TICK_RELOAD(TICK_RELOAD),
		.FRAME_RELOAD(FRAME_RELOAD),
		.PCLK_DIV(PCLK_DIV)
	) u_timers (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.t(tif.tmr)
	);

	// Window check used throughout the state machine
	function automatic logic in_win(input logic [15:0] v, input logic [15:0] lo,
			input logic [15:0] hi);
		return v >= lo && v <= hi;
	endfunction : in_win

	logic sync1; // First synchroniser stage, read only by sync2
	logic sync2; // Second synchroniser stage
	logic sync3; // Delayed copy for edge detection
	logic edge_seen; // Either edge of the waveform
	logic [5:0] bt_div; // Divide-by-50 prescaler of the base timer
	logic [15:0] base_timer; // Free-running base timer
	logic [15:0] edge_capture_value; // Base timer at the last edge
	logic [15:0] width; // Interval that just ended
	irrc_pkg::irrc_state_type state; // Receiver state
	logic [4:0] bcnt; // Bit cells accepted in this frame
	logic [31:0] shreg; // Incoming code bits, LSB first
	logic [7:0] custom_code; // Last accepted custom code
	logic [7:0] data_code; // Last accepted data code
	logic enable; // Receiver enable from the control register
	logic [3:0] status; // Sticky event bits
	logic [3:0] mask; // Interrupt mask
	logic [3:0] ev; // Event pulses from the receiver
	logic [3:0] next_status; // Status after set and clear
	logic [3:0] next_mask; // Mask after a bus write
	logic wb_req; // New bus request this cycle
	logic wb_wr; // Accepted write to byte lane 0
	logic restart; // Frame timer reload request
	logic cmp_ok; // Both bytes match their complements

	// Two-flop synchroniser and one more stage for edges
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end else begin
			sync1 <= remote_waveform_i;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end
	assign edge_seen = sync2 ^ sync3;

	// Base timer; nothing but reset ever clears it, no input filter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bt_div <= 6'h00;
			base_timer <= 16'h0000;
		end else if (tif.pstb) begin
			if (bt_div == 6'(BT_DIV - 1)) begin
				bt_div <= 6'h00;
				base_timer <= base_timer + 16'h0001;
			end else begin
				bt_div <= bt_div + 6'h01;
			end
		end
	end

	// Capture on both edges; width wraps safely since every window fits 16 bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			edge_capture_value <= 16'h0000;
		end else if (edge_seen) begin
			edge_capture_value <= base_timer;
		end
	end
	assign width = base_timer - edge_capture_value;
	assign cmp_ok = shreg[7:0] == ~shreg[15:8] && shreg[23:16] == ~shreg[31:24];
	assign tif.restart = restart;

	// Frame state machine, advanced on each waveform edge or frame expiry
	always_ff @(posedge clk_i) begin
		ev <= 4'h0;
		restart <= 1'b0;
		if (rst_i || !enable) begin
			state <= irrc_pkg::S_IDLE;
			bcnt <= 5'h00;
		end else if (edge_seen) begin
			case (state)
				// Any edge after idle or an error starts a first-frame leader
				irrc_pkg::S_IDLE: begin
					state <= irrc_pkg::S_LEAD_H;
					restart <= 1'b1;
				end
				irrc_pkg::S_LEAD_H: begin
					if (in_win(width, irrc_pkg::LH_LO, irrc_pkg::LH_HI)) begin
						state <= irrc_pkg::S_LEAD_L;
					end else begin
						state <= irrc_pkg::S_IDLE;
						ev[irrc_pkg::ST_RANGE] <= 1'b1;
					end
				end
				irrc_pkg::S_LEAD_L: begin
					if (in_win(width, irrc_pkg::LL_LO, irrc_pkg::LL_HI)) begin
						state <= irrc_pkg::S_BIT_H;
						bcnt <= 5'h00;
					end else begin
						state <= irrc_pkg::S_IDLE;
						ev[irrc_pkg::ST_RANGE] <= 1'b1;
					end
				end
				irrc_pkg::S_BIT_H: begin
					if (in_win(width, irrc_pkg::BIT_LO, irrc_pkg::BIT_HI)) begin
						state <= irrc_pkg::S_BIT_L;
					end else begin
						state <= irrc_pkg::S_IDLE;
						ev[irrc_pkg::ST_RANGE] <= 1'b1;
					end
				end
				// Low length decides the bit; 32 cells make the four bytes
				irrc_pkg::S_BIT_L: begin
					if (in_win(width, irrc_pkg::BIT_LO, irrc_pkg::BIT_HI)
							|| in_win(width, irrc_pkg::ONE_LO, irrc_pkg::ONE_HI)) begin
						state <= (bcnt == irrc_pkg::LAST_BIT) ? irrc_pkg::S_STOP
							: irrc_pkg::S_BIT_H;
						bcnt <= bcnt + 5'h01;
					end else begin
						state <= irrc_pkg::S_IDLE;
						ev[irrc_pkg::ST_RANGE] <= 1'b1;
					end
				end
				irrc_pkg::S_STOP: begin
					if (!in_win(width, irrc_pkg::BIT_LO, irrc_pkg::BIT_HI)) begin
						state <= irrc_pkg::S_IDLE;
						ev[irrc_pkg::ST_RANGE] <= 1'b1;
					end else if (!cmp_ok) begin
						state <= irrc_pkg::S_IDLE;
						ev[irrc_pkg::ST_CMP] <= 1'b1;
					end else begin
						state <= irrc_pkg::S_SPACE;
					end
				end
				// Leader after a good space, inside the frame, is a repeat
				irrc_pkg::S_SPACE: begin
					if (in_win(width, irrc_pkg::FS_LO, irrc_pkg::FS_HI)) begin
						state <= irrc_pkg::S_RLEAD_H;
						restart <= 1'b1;
						ev[irrc_pkg::ST_DONE] <= 1'b1;
					end else begin
						state <= irrc_pkg::S_IDLE;
						ev[irrc_pkg::ST_RANGE] <= 1'b1;
					end
				end
				irrc_pkg::S_RLEAD_H: begin
					if (in_win(width, irrc_pkg::LH_LO, irrc_pkg::LH_HI)) begin
						state <= irrc_pkg::S_RLEAD_L;
					end else begin
						state <= irrc_pkg::S_IDLE;
						ev[irrc_pkg::ST_RANGE] <= 1'b1;
					end
				end
				irrc_pkg::S_RLEAD_L: begin
					if (in_win(width, irrc_pkg::RLL_LO, irrc_pkg::RLL_HI)) begin
						state <= irrc_pkg::S_RSTOP;
					end else begin
						state <= irrc_pkg::S_IDLE;
						ev[irrc_pkg::ST_RANGE] <= 1'b1;
					end
				end
				irrc_pkg::S_RSTOP: begin
					if (in_win(width, irrc_pkg::BIT_LO, irrc_pkg::BIT_HI)) begin
						state <= irrc_pkg::S_RSPACE;
					end else begin
						state <= irrc_pkg::S_IDLE;
						ev[irrc_pkg::ST_RANGE] <= 1'b1;
					end
				end
				irrc_pkg::S_RSPACE: begin
					if (in_win(width, irrc_pkg::RFS_LO, irrc_pkg::RFS_HI)) begin
						state <= irrc_pkg::S_RLEAD_H;
						restart <= 1'b1;
						ev[irrc_pkg::ST_REP] <= 1'b1;
					end else begin
						state <= irrc_pkg::S_IDLE;
						ev[irrc_pkg::ST_RANGE] <= 1'b1;
					end
				end
				default: begin
					state <= irrc_pkg::S_IDLE;
				end
			endcase
		end else if (tif.expired) begin
			// Frame window over: complete if in a space, no effect when idle, otherwise too long
			case (state)
				irrc_pkg::S_IDLE: begin
					state <= irrc_pkg::S_IDLE;
				end
				irrc_pkg::S_SPACE: begin
					state <= irrc_pkg::S_IDLE;
					ev[irrc_pkg::ST_DONE] <= 1'b1;
				end
				irrc_pkg::S_RSPACE: begin
					state <= irrc_pkg::S_IDLE;
					ev[irrc_pkg::ST_REP] <= 1'b1;
				end
				default: begin
					state <= irrc_pkg::S_IDLE;
					ev[irrc_pkg::ST_RANGE] <= 1'b1;
				end
			endcase
		end
	end

	// Bit shifter, LSB first, and code latch once the stop bit checks out
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shreg <= 32'h0000_0000;
			custom_code <= 8'h00;
			data_code <= 8'h00;
		end else if (edge_seen && state == irrc_pkg::S_BIT_L) begin
			shreg <= {in_win(width, irrc_pkg::ONE_LO, irrc_pkg::ONE_HI), shreg[31:1]};
		end else if (edge_seen && state == irrc_pkg::S_STOP && cmp_ok
				&& in_win(width, irrc_pkg::BIT_LO, irrc_pkg::BIT_HI)) begin
			custom_code <= shreg[7:0];
			data_code <= shreg[23:16];
		end
	end

	// Status: hardware set wins over a write-one clear in the same cycle
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
	// The interrupt uses the new mask too, so it never lags a mask write
	always_comb begin
		next_status = status;
		next_mask = mask;
		if (wb_wr && wb_adr_i == irrc_pkg::STAT_OFS) begin
			next_status = status & ~wb_dat_i[3:0];
		end
		if (wb_wr && wb_adr_i == irrc_pkg::MASK_OFS) begin
			next_mask = wb_dat_i[3:0];
		end
		next_status = next_status | ev;
	end

	// Control, mask, status and interrupt registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enable <= irrc_pkg::CTRL_RST;
			mask <= irrc_pkg::MASK_RST;
			status <= 4'h0;
			irq_o <= 1'b0;
		end else begin
			status <= next_status;
			mask <= next_mask;
			irq_o <= |(next_status & next_mask);
			if (wb_wr && wb_adr_i == irrc_pkg::CTRL_OFS) begin
				enable <= wb_dat_i[0];
			end
		end
	end

	// Bus answer: ack one cycle after the request, unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req) begin
				case (wb_adr_i)
					irrc_pkg::CTRL_OFS: wb_dat_o <= {31'h0, enable};
					irrc_pkg::STAT_OFS: wb_dat_o <= {28'h0, status};
					irrc_pkg::MASK_OFS: wb_dat_o <= {28'h0, mask};
					irrc_pkg::CODE_OFS: wb_dat_o <= {16'h0, data_code, custom_code};
					irrc_pkg::CAPT_OFS: wb_dat_o <= {12'h0, 4'(state), edge_capture_value};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	capture_on_edge_a: assert property (edge_seen |=> edge_capture_value == $past(base_timer))
		else $error("capture missed an edge");
	base_divide_a: assert property (!(tif.pstb && bt_div == 6'(BT_DIV - 1)) |=> $stable(base_timer))
		else $error("base timer moved off its divided clock");
	lead_window_a: assert property (state == irrc_pkg::S_LEAD_H && edge_seen && enable
			&& (width < irrc_pkg::LH_LO || width > irrc_pkg::LH_HI)
			|=> state == irrc_pkg::S_IDLE && ev[irrc_pkg::ST_RANGE])
		else $error("bad leader high accepted");
	one_bit_a: assert property (state == irrc_pkg::S_BIT_L && edge_seen && enable
			&& in_win(width, irrc_pkg::ONE_LO, irrc_pkg::ONE_HI) |=> shreg[31])
		else $error("one bit not shifted in");
	complete_a: assert property (state == irrc_pkg::S_SPACE && tif.expired && !edge_seen
			&& enable |=> ev[irrc_pkg::ST_DONE] ##1 status[irrc_pkg::ST_DONE])
		else $error("frame not completed on expiry in space");
	cmp_error_a: assert property (state == irrc_pkg::S_STOP && edge_seen && enable && !cmp_ok
			|=> ev[irrc_pkg::ST_CMP] && state == irrc_pkg::S_IDLE)
		else $error("complement mismatch not flagged");
	repeat_restart_a: assert property (ev[irrc_pkg::ST_REP] && state == irrc_pkg::S_RLEAD_H
			|-> restart)
		else $error("repeat leader did not restart frame timer");
	irq_level_a: assert property (irq_o == |(status & mask))
		else $error("interrupt low with unmasked status");
	first_done_c: cover property (ev[irrc_pkg::ST_DONE]);
	repeat_done_c: cover property (ev[irrc_pkg::ST_REP]);
	range_err_c: cover property (ev[irrc_pkg::ST_RANGE]);
	cmp_err_c: cover property (ev[irrc_pkg::ST_CMP]);
endmodule : irrc_decoder
`default_nettype wire

/* src/irrc_pkg.sv */
// Shared constants, timing windows and state type of the remote-frame receiver
package irrc_pkg;
	// Clock rates: system clock and the peripheral count clock derived from it
	localparam int unsigned CLK_HZ = 200000000;
	localparam int unsigned PCLK_HZ = 25000000;
	localparam int unsigned PCLK_DIV = CLK_HZ / PCLK_HZ;
	// Base timer divides the peripheral count clock by this ratio
	localparam int unsigned BT_DIV = 50;
	localparam int unsigned BT_NS = (BT_DIV * 1000) / (PCLK_HZ / 1000000);
	// Tick timer period in ms and its reload count in peripheral clocks
	localparam int unsigned TICK_MS = 1;
	localparam int unsigned TICK_RELOAD = (PCLK_HZ / 1000) * TICK_MS;
	// Frame window in ms, counted in ticks
	localparam int unsigned FRAME_MS = 140;
	localparam int unsigned FRAME_RELOAD = FRAME_MS / TICK_MS;
	// Interval windows in microseconds, nominal +-30 percent
	localparam int unsigned LH_MIN_US = 6300;
	localparam int unsigned LH_MAX_US = 11700;
	localparam int unsigned LL_MIN_US = 3150;
	localparam int unsigned LL_MAX_US = 5850;
	localparam int unsigned BIT_MIN_US = 392;
	localparam int unsigned BIT_MAX_US = 728;
	localparam int unsigned ONE_MIN_US = 1184;
	localparam int unsigned ONE_MAX_US = 2196;
	localparam int unsigned FS_MIN_US = 28350;
	localparam int unsigned FS_MAX_US = 52650;
	localparam int unsigned RLL_MIN_US = 1576;
	localparam int unsigned RLL_MAX_US = 2924;
	localparam int unsigned RFS_MIN_US = 67334;
	localparam int unsigned RFS_MAX_US = 125046;
	// Same windows in base timer ticks; least rounds up, longest rounds down
	localparam logic [15:0] LH_LO = 16'((LH_MIN_US * 1000 + BT_NS - 1) / BT_NS);
	localparam logic [15:0] LH_HI = 16'((LH_MAX_US * 1000) / BT_NS);
	localparam logic [15:0] LL_LO = 16'((LL_MIN_US * 1000 + BT_NS - 1) / BT_NS);
	localparam logic [15:0] LL_HI = 16'((LL_MAX_US * 1000) / BT_NS);
	localparam logic [15:0] BIT_LO = 16'((BIT_MIN_US * 1000 + BT_NS - 1) / BT_NS);
	localparam logic [15:0] BIT_HI = 16'((BIT_MAX_US * 1000) / BT_NS);
	localparam logic [15:0] ONE_LO = 16'((ONE_MIN_US * 1000 + BT_NS - 1) / BT_NS);
	localparam logic [15:0] ONE_HI = 16'((ONE_MAX_US * 1000) / BT_NS);
	localparam logic [15:0] FS_LO = 16'((FS_MIN_US * 1000 + BT_NS - 1) / BT_NS);
	localparam logic [15:0] FS_HI = 16'((FS_MAX_US * 1000) / BT_NS);
	localparam logic [15:0] RLL_LO = 16'((RLL_MIN_US * 1000 + BT_NS - 1) / BT_NS);
	localparam logic [15:0] RLL_HI = 16'((RLL_MAX_US * 1000) / BT_NS);
	localparam logic [15:0] RFS_LO = 16'((RFS_MIN_US * 1000 + BT_NS - 1) / BT_NS);
	localparam logic [15:0] RFS_HI = 16'((RFS_MAX_US * 1000) / BT_NS);
	// Bits per frame: four code bytes
	localparam logic [4:0] LAST_BIT = 5'h1F;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] MASK_OFS = 8'h08;
	localparam logic [7:0] CODE_OFS = 8'h0C;
	localparam logic [7:0] CAPT_OFS = 8'h10;
	// Status bit positions
	localparam int unsigned ST_DONE = 0;
	localparam int unsigned ST_REP = 1;
	localparam int unsigned ST_RANGE = 2;
	localparam int unsigned ST_CMP = 3;
	// Reset values
	localparam logic CTRL_RST = 1'b0;
	localparam logic [3:0] MASK_RST = 4'h0;
	// Receiver states
	typedef enum logic [3:0] {
		S_IDLE, S_LEAD_H, S_LEAD_L, S_BIT_H, S_BIT_L, S_STOP, S_SPACE,
		S_RLEAD_H, S_RLEAD_L, S_RSTOP, S_RSPACE
	} irrc_state_type;
endpackage : irrc_pkg

/* src/irrc_timers.sv */
// Peripheral clock divider, 1 ms tick timer and frame timer
`timescale 1ns/1ps
`default_nettype none
module irrc_timers #(
	parameter int unsigned TICK_RELOAD = irrc_pkg::TICK_RELOAD,
	parameter int unsigned FRAME_RELOAD = irrc_pkg::FRAME_RELOAD,
	parameter int unsigned PCLK_DIV = irrc_pkg::PCLK_DIV
) (
	input wire logic clk_i,
	input wire logic rst_i,
	irrc_tmr_if.tmr t
);
	logic [3:0] pdiv; // System clock divider
	logic [14:0] tick_cnt; // Tick timer, counts peripheral clocks
	logic tick; // Tick timer underflow
	logic [7:0] frame_cnt; // Frame timer, counts ticks down

	// Peripheral count clock strobe, one system clock wide
	always_ff @(posedge clk_i) begin
		if (rst_i || pdiv == 4'(PCLK_DIV - 1)) begin
			pdiv <= 4'h0;
		end else begin
			pdiv <= pdiv + 4'h1;
		end
		t.pstb <= !rst_i && pdiv == 4'(PCLK_DIV - 1);
	end

	// Tick timer in plain timer mode, free running, no gate
	always_ff @(posedge clk_i) begin
		tick <= 1'b0;
		if (rst_i) begin
			tick_cnt <= 15'(TICK_RELOAD - 1);
		end else if (t.pstb) begin
			if (tick_cnt == 15'h0) begin
				tick_cnt <= 15'(TICK_RELOAD - 1);
				tick <= 1'b1;
			end else begin
				tick_cnt <= tick_cnt - 15'h1;
			end
		end
	end

	// Frame timer counts tick underflows down and reloads on its own underflow
	always_ff @(posedge clk_i) begin
		t.expired <= 1'b0;
		if (rst_i || t.restart) begin
			frame_cnt <= 8'(FRAME_RELOAD - 1);
		end else if (tick) begin
			if (frame_cnt == 8'h0) begin
				frame_cnt <= 8'(FRAME_RELOAD - 1);
				t.expired <= 1'b1;
			end else begin
				frame_cnt <= frame_cnt - 8'h1;
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	tick_period_a: assert property (tick |-> $past(tick_cnt) == 15'h0 && $past(t.pstb))
		else $error("tick without tick timer underflow");
	frame_reload_a: assert property (t.restart |=> frame_cnt == 8'(FRAME_RELOAD - 1))
		else $error("frame timer not reloaded");
	frame_step_a: assert property (t.expired |-> $past(frame_cnt) == 8'h0 && $past(tick))
		else $error("frame expiry without frame timer underflow");
endmodule : irrc_timers
`default_nettype wire

/* src/irrc_tmr_if.sv */
// Link between the decoder core and its clock-divider and frame timers
`timescale 1ns/1ps
`default_nettype none
interface irrc_tmr_if;
	logic pstb; // Peripheral count clock strobe
	logic restart; // Reload the frame timer
	logic expired; // Frame timer underflow pulse
	modport tmr (output pstb, output expired, input restart);
	modport core (input pstb, input expired, output restart);
endinterface : irrc_tmr_if
`default_nettype wire

/* verification/irrc_ir_tx.sv */
// Behavioural infrared receiver module that drives the demodulated remote waveform
`timescale 1ns/1ps
`default_nettype none
module irrc_ir_tx #(
	// Clocks per base timer tick: count clock divider times base divider
	parameter int TICK_CLK = irrc_pkg::PCLK_DIV * irrc_pkg::BT_DIV
) (
	input wire logic clk_i,
	output var logic wave_o
);
	// Interval lengths in ticks, kept near the short end of each window to save run time
	localparam int LEAD_H = 3200;
	localparam int LEAD_L = 1600;
	localparam int BIT_T = 200;
	localparam int ONE_T = 600;
	localparam int SPACE_T = 14200;
	localparam int RLEAD_L = 800;

	// The real module drives the line low between bursts, so low is a true level
	initial wave_o = 1'b0;

	// Drive one level for a whole number of ticks; edges land on rising clock edges
	task automatic pulse(input logic lvl, input int ticks);
		wave_o <= lvl;
		repeat (ticks * TICK_CLK) @(posedge clk_i);
	endtask : pulse

	// One first frame: leader, four code bytes, stop bit, then the frame space
	task automatic send_frame(input logic [7:0] cust, input logic [7:0] dat);
		logic [31:0] w;
		w = {~dat, dat, ~cust, cust};
		pulse(1'b1, LEAD_H);
		pulse(1'b0, LEAD_L);
		for (int i = 0; i < 32; i++) begin
			pulse(1'b1, BIT_T);
			pulse(1'b0, w[i] ? ONE_T : BIT_T);
		end
		pulse(1'b1, BIT_T);
		pulse(1'b0, SPACE_T);
	endtask : send_frame

	// One repeat frame: leader, short leader low, stop bit; the line then stays low
	task automatic send_repeat;
		pulse(1'b1, LEAD_H);
		pulse(1'b0, RLEAD_L);
		pulse(1'b1, BIT_T);
		wave_o <= 1'b0;
	endtask : send_repeat
endmodule : irrc_ir_tx
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the remote-frame receiver over its Wishbone registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_i; // 200 MHz clock
	logic rst_i; // Synchronous reset
	logic [7:0] wb_adr;
	logic [31:0] wb_dat;
	logic wb_we;
	logic [3:0] wb_sel;
	logic wb_cyc;
	logic wb_stb;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic wave; // Remote waveform from the partner model
	logic irq_o;
	logic [31:0] q; // Last read word
	logic [31:0] c1; // First capture snapshot
	int n_mismatch;
	int check_count;

	// One base tick per clock and a 300-tick frame clock keep a frame under 40k cycles;
	// the 140-tick window then spans 42000 base ticks, still past the test frame
	irrc_decoder #(
		.TICK_RELOAD(300),
		.FRAME_RELOAD(irrc_pkg::FRAME_RELOAD),
		.PCLK_DIV(1),
		.BT_DIV(1)
	) dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_adr_i(wb_adr),
		.wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o),
		.wb_we_i(wb_we),
		.wb_sel_i(wb_sel),
		.wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb),
		.wb_ack_o(wb_ack_o),
		.remote_waveform_i(wave),
		.irq_o(irq_o)
	);

	irrc_ir_tx #(.TICK_CLK(1)) tx (
		.clk_i(clk_i),
		.wave_o(wave)
	);

	// Clock generator
	always #2.5 clk_i = ~clk_i;

	// Compare one value and count the outcome
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Classic single cycle; the request stands until ack is sampled high
	task automatic wb_cycle(input logic [7:0] a, input logic we, input logic [31:0] d);
		int n;
		n = 0;
		wb_adr <= a;
		wb_we <= we;
		wb_dat <= d;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		q = wb_dat_o;
		if (n >= 20) n_mismatch++;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		// One idle cycle so the next request never lands in the same step
		@(posedge clk_i);
	endtask : wb_cycle

	// Read a register and compare it in full
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		wb_cycle(a, 1'b0, 32'h0);
		check(q, exp);
	endtask : rd_chk

	// Print the counts and the verdict, then stop
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	// Watchdog: a first frame and a repeat window take about 81k cycles
	initial begin
		#480000;
		n_mismatch++;
		end_sim();
	end

	// Main sequence
	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		wb_adr = 8'h00;
		wb_dat = 32'h0;
		wb_we = 1'b0;
		wb_sel = 4'hF;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		n_mismatch = 0;
		check_count = 0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);

		// Reset values, read-write fields and an unmapped place
		rd_chk(irrc_pkg::CTRL_OFS, 32'h0);
		rd_chk(irrc_pkg::STAT_OFS, 32'h0);
		rd_chk(irrc_pkg::MASK_OFS, 32'h0);
		wb_cycle(8'h20, 1'b1, 32'hFFFFFFFF);
		rd_chk(8'h20, 32'h0);
		wb_cycle(irrc_pkg::MASK_OFS, 1'b1, 32'h0000000F);
		// Byte lane 0 disabled: the write must leave the mask alone
		wb_sel <= 4'hE;
		wb_cycle(irrc_pkg::MASK_OFS, 1'b1, 32'h00000000);
		wb_sel <= 4'hF;
		rd_chk(irrc_pkg::MASK_OFS, 32'h0000000F);
		wb_cycle(irrc_pkg::MASK_OFS, 1'b1, 32'h00000004);
		wb_cycle(irrc_pkg::CTRL_OFS, 1'b1, 32'h00000001);
		rd_chk(irrc_pkg::CTRL_OFS, 32'h00000001);
		check({31'h0, irq_o}, 32'h0);
		$display("test registers done");

		// Short leader high: both edges captured, interval refused
		fork
			tx.pulse(1'b1, 50);
		join_none
		repeat (10) @(posedge clk_i);
		wb_cycle(irrc_pkg::CAPT_OFS, 1'b0, 32'h0);
		c1 = q;
		check({28'h0, c1[19:16]}, 32'(irrc_pkg::S_LEAD_H));
		wait fork;
		fork
			tx.pulse(1'b0, 10);
		join_none
		repeat (10) @(posedge clk_i);
		wb_cycle(irrc_pkg::CAPT_OFS, 1'b0, 32'h0);
		check({16'h0, q[15:0] - c1[15:0]}, 32'h00000032);
		check({28'h0, q[19:16]}, 32'(irrc_pkg::S_IDLE));
		rd_chk(irrc_pkg::STAT_OFS, 32'h00000004);
		check({31'h0, irq_o}, 32'h00000001);
		wb_cycle(irrc_pkg::STAT_OFS, 1'b1, 32'h00000004);
		repeat (3) @(posedge clk_i);
		check({31'h0, irq_o}, 32'h0);
		rd_chk(irrc_pkg::STAT_OFS, 32'h0);
		wait fork;
		$display("test capture and range done");

		// Full first frame, space ended by a repeat leader; the repeat ends on frame expiry
		wb_cycle(irrc_pkg::MASK_OFS, 1'b1, 32'h00000003);
		tx.send_frame(8'hA5, 8'h3C);
		fork
			tx.send_repeat();
		join_none
		repeat (10) @(posedge clk_i);
		rd_chk(irrc_pkg::STAT_OFS, 32'h00000001);
		wb_cycle(irrc_pkg::CODE_OFS, 1'b0, 32'h0);
		check({16'h0, q[15:0]}, 32'h00003CA5);
		wb_cycle(irrc_pkg::CAPT_OFS, 1'b0, 32'h0);
		check({28'h0, q[19:16]}, 32'(irrc_pkg::S_RLEAD_H));
		check({31'h0, irq_o}, 32'h00000001);
		wait fork;
		// Window restarted at the repeat leader runs out inside the repeat space
		repeat (38200) @(posedge clk_i);
		rd_chk(irrc_pkg::STAT_OFS, 32'h00000003);
		wb_cycle(irrc_pkg::CAPT_OFS, 1'b0, 32'h0);
		check({28'h0, q[19:16]}, 32'(irrc_pkg::S_IDLE));
		wb_cycle(irrc_pkg::MASK_OFS, 1'b1, 32'h0);
		repeat (3) @(posedge clk_i);
		check({31'h0, irq_o}, 32'h0);
		wb_cycle(irrc_pkg::STAT_OFS, 1'b1, 32'h00000003);
		rd_chk(irrc_pkg::STAT_OFS, 32'h0);
		$display("test first frame done");
		end_sim();
	end
endmodule : testbench
`default_nettype wire
